/* File: hw/mlb_bus.sv */
// Multiplexed local bus interface: address, address/data lanes, latch strobe, ready
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module mlb_bus
  import mlb_pkg::*;
#(
  parameter bit NARROW = 1'b0  // 1: 8-bit data variant with address-only lanes
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       resetn,
  // Core request
  input  wire logic                       req_valid,
  input  wire logic [mlb_pkg::ADDR_W-1:0] req_addr,
  input  wire logic                       req_write,
  input  wire logic [1:0]                 req_cycle_enc,
  input  wire logic                       req_chip_select,
  input  wire logic [mlb_pkg::LANE_W-1:0] req_wdata,
  output logic                            req_ready,
  output logic                            rsp_valid,
  output logic [mlb_pkg::LANE_W-1:0]      rsp_rdata,
  // Control
  input  wire logic                       bus_hold,
  input  wire logic                       on_circuit_emulation_mode,
  input  wire logic                       address_disable_bit,
  // Ready inputs
  input  wire logic                       async_ready_in,
  input  wire logic                       sync_ready_in,
  // Strap
  input  wire logic                       address_enable_strap,
  // Nonmultiplexed address
  output logic [mlb_pkg::ADDR_W-1:0]      nonmuxed_address_out,
  output logic                            nonmuxed_address_oe_n,
  // Multiplexed address/data lanes
  input  wire logic [mlb_pkg::LANE_W-1:0] muxed_addr_data_lanes_in,
  output logic [mlb_pkg::LANE_W-1:0]      muxed_addr_data_lanes_out,
  output logic [1:0]                      muxed_lane_oe_n,
  // Address-only lanes of the narrow variant
  output logic [mlb_pkg::BYTE_W-1:0]      address_only_high_lanes,
  output logic                            address_only_oe_n,
  // Strobes and encodings
  output logic                            addr_latch_strobe,
  output logic                            addr_latch_oe_n,
  output logic                            byte_high_enable,
  output logic                            low_byte_write_enable,
  output logic                            high_byte_write_enable,
  // Configuration results
  output logic [mlb_pkg::CFG_W-1:0]       reset_config,
  output logic                            status_pins_normal
);

  mlb_state_t          state_q;
  logic [ADDR_W-1:0]   addr_q;
  logic [LANE_W-1:0]   wdata_q;
  logic                write_q;
  logic [1:0]          enc_q;
  logic                sel_q;
  logic                strap_seen_q;
  logic                async_ready_in_sync;
  logic                cycle_ready;
  logic                hold_or_reset;
  logic                addr_phase_off;
  logic                addr_lead_q;

  // ==========================================================
  // Asynchronous ready: both edges synchronised, active high
  mlb_sync3 u_async_ready_in_sync (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in (async_ready_in),
    .sync_out (async_ready_in_sync)
  );

  // Held high means every cycle ready; low leaves sync ready in charge
  assign cycle_ready = async_ready_in_sync | sync_ready_in;

  // Bus hold floats the bus only between cycles
  assign hold_or_reset = bus_hold && (state_q == MLB_IDLE);

  // Address phase suppressed only when strap was high at reset release; judged on
  // the request being taken, since the captured select still holds the last cycle
  assign addr_phase_off = !strap_seen_q && req_chip_select && address_disable_bit;

  // ==========================================================
  // Bus cycle sequencer, all outputs on sys_clk edges
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= MLB_IDLE;
    end else begin
      unique case (state_q)
        MLB_IDLE: begin
          if (req_valid && !bus_hold) begin
            state_q <= MLB_T1;
          end
        end
        MLB_T1:   state_q <= MLB_T2;
        MLB_T2:   state_q <= MLB_T3;
        MLB_T3,
        MLB_TW: begin
          // Stretch with wait states until ready arrives
          state_q <= cycle_ready ? MLB_T4 : MLB_TW;
        end
        MLB_T4:   state_q <= MLB_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Request capture
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      addr_q  <= ADDR_RST;
      wdata_q <= LANE_RST;
      write_q <= 1'b0;
      enc_q   <= ENC_WORD;
      sel_q   <= 1'b0;
    end else if (state_q == MLB_IDLE && req_valid && !bus_hold) begin
      addr_q  <= req_addr;
      wdata_q <= req_wdata;
      write_q <= req_write;
      enc_q   <= req_cycle_enc;
      sel_q   <= req_chip_select;
    end
  end

  // ==========================================================
  // Core handshake
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= LANE_RST;
    end else begin
      req_ready <= (state_q == MLB_IDLE) && !req_valid && !bus_hold;
      rsp_valid <= (state_q == MLB_T4);
      if (state_q == MLB_T4 && !write_q) begin
        rsp_rdata <= muxed_addr_data_lanes_in;
      end
    end
  end

  // ==========================================================
  // Nonmuxed address: driven on the same sys_clk edge as the lane address,
  // with no half-period lead over the lanes; this level marks T1
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      nonmuxed_address_out  <= ADDR_RST;
      nonmuxed_address_oe_n <= 1'b1;
      addr_lead_q           <= 1'b0;
    end else begin
      addr_lead_q <= (state_q == MLB_IDLE) && req_valid && !bus_hold;
      if (state_q == MLB_IDLE && req_valid && !bus_hold) begin
        nonmuxed_address_out <= req_addr;
      end
      nonmuxed_address_oe_n <= hold_or_reset;
    end
  end

  // ==========================================================
  // Muxed lanes: address in T1, data in T2..T4, floated per byte enable
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      muxed_addr_data_lanes_out <= LANE_RST;
      muxed_lane_oe_n           <= 2'h3;
    end else begin
      if (hold_or_reset) begin
        muxed_lane_oe_n <= 2'h3;
      end else if (state_q == MLB_IDLE && req_valid) begin
        // Entering T1: address phase
        muxed_addr_data_lanes_out <= req_addr[LANE_W-1:0];
        muxed_lane_oe_n[0] <= addr_lead_q & 1'b0;
        muxed_lane_oe_n[1] <= NARROW;
        if (!strap_seen_q && req_chip_select && address_disable_bit) begin
          muxed_lane_oe_n <= 2'h3;
        end
      end else if (state_q == MLB_T1) begin
        // Entering T2: data phase, float unwritten lanes
        muxed_addr_data_lanes_out <= wdata_q;
        muxed_lane_oe_n[0] <= !(write_q && low_byte_write_enable);
        muxed_lane_oe_n[1] <= NARROW || !(write_q && high_byte_write_enable);
      end else if (state_q == MLB_T4) begin
        muxed_lane_oe_n <= 2'h3;
      end
    end
  end

  // ==========================================================
  // Address-only lanes of the narrow variant, valid T1..T4
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      address_only_high_lanes <= 8'h00;
      address_only_oe_n       <= 1'b1;
    end else begin
      if (state_q == MLB_IDLE && req_valid && !bus_hold) begin
        address_only_high_lanes <= req_addr[LANE_W-1:BYTE_W];
      end
      address_only_oe_n <= !NARROW || hold_or_reset;
    end
  end

  // ==========================================================
  // Latch strobe high in T1; trailing edge latches a stable address
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      addr_latch_strobe <= 1'b0;
      addr_latch_oe_n   <= 1'b0;
    end else begin
      addr_latch_strobe <= (state_q == MLB_IDLE) && req_valid && !bus_hold
                           && !addr_phase_off;
      // Floats only in emulation mode, never for hold or reset
      addr_latch_oe_n   <= on_circuit_emulation_mode;
    end
  end

  // ==========================================================
  // Byte-high enable and byte write enables from the cycle encoding
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      byte_high_enable       <= 1'b1;
      low_byte_write_enable  <= 1'b0;
      high_byte_write_enable <= 1'b0;
    end else if (state_q == MLB_IDLE && req_valid && !bus_hold) begin
      byte_high_enable       <= req_cycle_enc[1];
      low_byte_write_enable  <= req_write && (req_cycle_enc == ENC_WORD
                                || req_cycle_enc == ENC_LOW);
      high_byte_write_enable <= req_write && !NARROW && (req_cycle_enc == ENC_WORD
                                || req_cycle_enc == ENC_HIGH);
    end else if (state_q == MLB_T4) begin
      byte_high_enable       <= 1'b1;
      low_byte_write_enable  <= 1'b0;
      high_byte_write_enable <= 1'b0;
    end
  end

  // ==========================================================
  // Straps: sampled on the first edge after reset release, since an
  // asynchronous reset may only load constants
  logic first_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      first_q            <= 1'b1;
      strap_seen_q       <= 1'b0;
      reset_config       <= CFG_RST;
      status_pins_normal <= 1'b0;
    end else begin
      first_q <= 1'b0;
      if (first_q) begin
        reset_config       <= muxed_addr_data_lanes_in;
        strap_seen_q       <= !address_enable_strap;
        status_pins_normal <= !address_enable_strap;
      end
    end
  end

endmodule
`default_nettype wire

/* File: hw/mlb_pkg.sv */
// Package of constants and types for the multiplexed local bus interface
package mlb_pkg;

  // ==========================================================
  // Widths
  localparam int ADDR_W  = 20;
  localparam int LANE_W  = 16;
  localparam int BYTE_W  = 8;
  localparam int CFG_W   = 16;

  // ==========================================================
  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
  localparam logic [LANE_W-1:0] LANE_RST = 16'h0000;
  localparam logic [CFG_W-1:0]  CFG_RST  = 16'h0000;

  // ==========================================================
  // Byte-high enable / lowest address bit cycle encoding
  localparam logic [1:0] ENC_WORD    = 2'h0;
  localparam logic [1:0] ENC_HIGH    = 2'h1;
  localparam logic [1:0] ENC_LOW     = 2'h2;
  localparam logic [1:0] ENC_REFRESH = 2'h3;

  // ==========================================================
  // Bus cycle states
  typedef enum logic [2:0] {
    MLB_IDLE,
    MLB_T1,
    MLB_T2,
    MLB_T3,
    MLB_TW,
    MLB_T4
  } mlb_state_t;

endpackage

/* File: hw/mlb_sync3.sv */
// Three-stage synchroniser with agreement filter for one asynchronous pin
`timescale 1ns/10ps
`default_nettype none
module mlb_sync3 (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  // Pin and filtered level
  input  wire logic async_in,
  output var  logic sync_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // ==========================================================
  // Chain; only the second stage reads the first
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ==========================================================
  // A change counts once stages two and three agree
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync_out <= 1'b0;
    end else if (s2_q == s3_q) begin
      sync_out <= s3_q;
    end
  end

endmodule
`default_nettype wire

/* File: verification/mlb_bus_properties.sv */
// Concurrent checks on the local bus pins of mlb_bus
`timescale 1ns/10ps
`default_nettype none
module mlb_bus_properties (
  // Clock, reset and controls
  input wire logic                        sys_clk,
  input wire logic                        resetn,
  input wire logic                        bus_hold,
  input wire logic                        on_circuit_emulation_mode,
  input wire logic                        async_ready_in,
  input wire logic                        sync_ready_in,
  // Bus pins
  input wire logic [mlb_pkg::ADDR_W-1:0] nonmuxed_address_out,
  input wire logic                        nonmuxed_address_oe_n,
  input wire logic [mlb_pkg::LANE_W-1:0] muxed_addr_data_lanes_out,
  input wire logic [1:0]                  muxed_lane_oe_n,
  input wire logic                        addr_latch_strobe,
  input wire logic                        addr_latch_oe_n,
  input wire logic                        low_byte_write_enable,
  input wire logic                        byte_high_enable,
  input wire logic                        rsp_valid
);
  import mlb_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Cycle steps; async ready must be low long enough to pass the synchroniser
  sequence s_ready_t3;
    addr_latch_strobe ##2 sync_ready_in;
  endsequence
  sequence s_stall;
    (!async_ready_in)[*3] ##1 (addr_latch_strobe && !async_ready_in)
      ##1 (!sync_ready_in && !async_ready_in)[*3];
  endsequence
  // ==========================================================
  // Properties
  a_t1_address: assert property (
    addr_latch_strobe && !(byte_high_enable && nonmuxed_address_out[0]) |->
      !muxed_lane_oe_n[0] && !nonmuxed_address_oe_n &&
      muxed_addr_data_lanes_out[7:0] == nonmuxed_address_out[7:0])
    else $error("low lanes do not carry the address in T1");
  a_strobe_pulse: assert property (
    addr_latch_strobe |=> !addr_latch_strobe ##1 !addr_latch_strobe)
    else $error("latch strobe longer than one cycle");
  a_addr_stable: assert property (
    addr_latch_strobe |=> $stable(nonmuxed_address_out)[*3])
    else $error("address moved during the cycle");
  a_ready_done: assert property (
    s_ready_t3 |-> ##2 rsp_valid)
    else $error("ready cycle did not finish after T4");
  a_wait_stall: assert property (
    s_stall |=> !rsp_valid)
    else $error("cycle finished without ready");
  a_resp_pulse: assert property (
    rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  a_lane_float: assert property (
    addr_latch_strobe ##1 !low_byte_write_enable |-> muxed_lane_oe_n[0])
    else $error("low lane driven without write enable");
  a_hold_float: assert property (
    bus_hold[*8] |-> nonmuxed_address_oe_n && muxed_lane_oe_n == 2'h3)
    else $error("bus driven during hold");
  a_latch_drive: assert property (
    !on_circuit_emulation_mode[*2] |-> !addr_latch_oe_n)
    else $error("latch strobe floated outside emulation");
  a_latch_float: assert property (
    on_circuit_emulation_mode[*2] |-> addr_latch_oe_n)
    else $error("latch strobe driven in emulation");
endmodule
bind mlb_bus mlb_bus_properties u_props (.sys_clk, .resetn, .bus_hold,
  .on_circuit_emulation_mode, .async_ready_in, .sync_ready_in,
  .nonmuxed_address_out, .nonmuxed_address_oe_n, .muxed_addr_data_lanes_out,
  .muxed_lane_oe_n, .addr_latch_strobe, .addr_latch_oe_n,
  .low_byte_write_enable, .byte_high_enable, .rsp_valid);
`default_nettype wire

/* File: verification/mlb_mem_model.sv */
// External memory, address latch and ready logic on the multiplexed lanes
`timescale 1ns/10ps
`default_nettype none
module mlb_mem_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Device pins
  input  wire logic [15:0] lanes_out,
  input  wire logic [1:0]  lane_oe_n,
  input  wire logic        strobe,
  output logic [15:0]      lanes_in,
  output logic             sync_ready,
  // Bench settings
  input  wire logic [15:0] cfg,
  input  wire logic [7:0]  waits
);
  logic [7:0]  addr_q;
  logic [7:0]  cnt_q;
  logic        cfg_q;
  logic [15:0] rd;
  logic [15:0] drv;
  // Latch the address as the strobe ends, then count cycles of the transfer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      addr_q <= 8'h00;
      cnt_q  <= 8'hff;
      cfg_q  <= 1'b1;
    end else begin
      cfg_q <= 1'b0;
      if (strobe) begin
        addr_q <= lanes_out[7:0];
        cnt_q  <= 8'h00;
      end else if (cnt_q != 8'hff) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
  // Config held one edge past reset; outside the data window the lanes flip
  assign rd         = {addr_q ^ 8'ha5, addr_q};
  assign drv        = cfg_q ? cfg :
                      ({1'b0, cnt_q} <= {1'b0, waits} + 9'h002) ? rd : ~rd;
  assign sync_ready = {1'b0, cnt_q} >= {1'b0, waits} + 9'h001;
  assign lanes_in   = {lane_oe_n[1] ? drv[15:8] : lanes_out[15:8],
                       lane_oe_n[0] ? drv[7:0] : lanes_out[7:0]};
endmodule
`default_nettype wire

/* File: verification/tb_mlb_bus.sv */
// Self-checking bench for the multiplexed local bus interface
`timescale 1ns/10ps
`default_nettype none
module tb_mlb_bus;
  import mlb_pkg::*;
  typedef struct {
    logic [19:0] a;
    logic        w;
    logic [1:0]  e;
    logic [15:0] d;
    logic [1:0]  oe;
    logic [15:0] m;
  } mlb_row_t;
  // ==========================================================
  // Signals
  logic sys_clk, resetn, req_valid, req_write, req_chip_select, req_ready, rsp_valid;
  logic bus_hold, on_circuit_emulation_mode, address_disable_bit, async_ready_in;
  logic sync_ready_in, address_enable_strap, nonmuxed_address_oe_n, addr_latch_strobe;
  logic addr_latch_oe_n, status_pins_normal, st_d, byte_high_enable, bhe_s;
  logic [19:0] req_addr, nonmuxed_address_out, s_addr;
  logic [15:0] req_wdata, rsp_rdata, lanes_in, lanes_out, reset_config, cfg, t2_out, q;
  logic [1:0]  req_cycle_enc, muxed_lane_oe_n, t2_oe;
  logic [7:0]  waits;
  int          n_errors, checked, lat, n_st, n0;
  mlb_row_t rows [6] = '{
    '{20'h12344, 1'b0, ENC_WORD, 16'h0000, 2'h3, 16'hffff},
    '{20'h00201, 1'b0, ENC_HIGH, 16'h0000, 2'h3, 16'hff00},
    '{20'h0a5a0, 1'b1, ENC_WORD, 16'hbeef, 2'h0, 16'h0000},
    '{20'h00101, 1'b1, ENC_HIGH, 16'h3300, 2'h1, 16'h0000},
    '{20'h00310, 1'b1, ENC_LOW, 16'h0077, 2'h2, 16'h0000},
    '{20'h00011, 1'b0, ENC_REFRESH, 16'h0000, 2'h3, 16'h0000}};
  mlb_bus #(.NARROW(1'b0)) u_dut (.sys_clk, .resetn, .req_valid, .req_addr, .req_write,
    .req_cycle_enc, .req_chip_select, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata,
    .bus_hold, .on_circuit_emulation_mode, .address_disable_bit, .async_ready_in,
    .sync_ready_in, .address_enable_strap, .nonmuxed_address_out, .nonmuxed_address_oe_n,
    .muxed_addr_data_lanes_in(lanes_in), .muxed_addr_data_lanes_out(lanes_out),
    .muxed_lane_oe_n, .address_only_high_lanes(), .address_only_oe_n(), .addr_latch_strobe,
    .addr_latch_oe_n, .byte_high_enable, .low_byte_write_enable(),
    .high_byte_write_enable(), .reset_config, .status_pins_normal);
  mlb_mem_model u_mem (.sys_clk, .resetn, .lanes_out, .lane_oe_n(muxed_lane_oe_n),
    .strobe(addr_latch_strobe), .lanes_in, .sync_ready(sync_ready_in), .cfg, .waits);
  // ==========================================================
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Capture the T1 address and the T2 lane view away from the sampling edge
  always @(negedge sys_clk) begin
    if (st_d === 1'b1) begin
      t2_out = lanes_out;
      t2_oe  = muxed_lane_oe_n;
    end
    if (addr_latch_strobe === 1'b1) begin
      s_addr = nonmuxed_address_out;
      bhe_s  = byte_high_enable;
      n_st++;
    end
    st_d = addr_latch_strobe;
  end
  // ==========================================================
  // Tasks
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One transfer; lat counts falling edges from the take to the response
  task automatic xfer(input mlb_row_t r);
    for (int i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge sys_clk);
    if (req_ready !== 1'b1) begin
      n_errors++;
      results();
    end
    @(posedge sys_clk);
    req_valid     <= 1'b1;
    req_addr      <= r.a;
    req_write     <= r.w;
    req_cycle_enc <= r.e;
    req_wdata     <= r.d;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    for (lat = 0; lat < 60 && rsp_valid !== 1'b1; lat++) @(negedge sys_clk);
    q = rsp_rdata;
    if (lat == 60) begin
      n_errors++;
      results();
    end
  endtask
  task automatic pulse_reset(input logic strap);
    @(posedge sys_clk);
    resetn               <= 1'b0;
    address_enable_strap <= strap;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(negedge sys_clk);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {resetn, req_valid, req_write, req_chip_select, bus_hold, async_ready_in} = '0;
    {on_circuit_emulation_mode, address_disable_bit, address_enable_strap} = '0;
    {req_addr, req_wdata, req_cycle_enc, waits, n_st} = '0;
    cfg = 16'hc3a5;
    repeat (3) @(negedge sys_clk);
    chk(nonmuxed_address_oe_n, 1'b1);
    chk(muxed_lane_oe_n, 2'h3);
    chk(addr_latch_oe_n, 1'b0);
    pulse_reset(1'b0);
    chk(reset_config, cfg);
    chk(status_pins_normal, 1'b1);
    // Back-to-back table rows: every encoding, reads and byte writes, no waits
    foreach (rows[k]) begin
      xfer(rows[k]);
      chk(s_addr, rows[k].a);
      chk(20'(lat), 20'd5);
      chk(bhe_s, rows[k].e[1]);
      chk(t2_oe, rows[k].oe);
      chk(t2_out & ~{{8{t2_oe[1]}}, {8{t2_oe[0]}}}, rows[k].d & ~{{8{rows[k].oe[1]}}, {8{rows[k].oe[0]}}});
      chk(q & rows[k].m, {rows[k].a[7:0] ^ 8'ha5, rows[k].a[7:0]} & rows[k].m);
    end
    // Three wait states from slow memory
    waits <= 8'h03;
    xfer(rows[0]);
    chk(20'(lat), 20'd8);
    // Async ready held high completes with sync ready low
    @(posedge sys_clk);
    waits          <= 8'hff;
    async_ready_in <= 1'b1;
    repeat (6) @(posedge sys_clk);
    xfer(rows[1]);
    chk(20'(lat), 20'd5);
    @(posedge sys_clk);
    async_ready_in <= 1'b0;
    waits          <= 8'h00;
    bus_hold       <= 1'b1;
    repeat (10) @(negedge sys_clk);
    chk(nonmuxed_address_oe_n, 1'b1);
    chk(muxed_lane_oe_n, 2'h3);
    chk({req_ready, addr_latch_oe_n}, 2'h0);
    @(posedge sys_clk);
    on_circuit_emulation_mode <= 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(addr_latch_oe_n, 1'b1);
    @(posedge sys_clk);
    {bus_hold, on_circuit_emulation_mode} <= 2'h0;
    // Strap high: chip-select cycles with address disable lose the address phase
    pulse_reset(1'b1);
    chk(status_pins_normal, 1'b0);
    req_chip_select     <= 1'b1;
    address_disable_bit <= 1'b1;
    n0 = n_st;
    xfer(rows[0]);
    chk(20'(n_st), 20'(n0));
    results();
  end
endmodule
`default_nettype wire
